// ==== rtl/aos_params.svh ====
`ifndef AOS_PARAMS_SVH
`define AOS_PARAMS_SVH
// Clock rate and self-test / repetition timing
`define AOS_CLK_HZ 125000000
`define AOS_SELFTEST_S 3
`define AOS_SELFTEST_CYC (`AOS_SELFTEST_S * `AOS_CLK_HZ)
`define AOS_REPEAT_MS 500
`define AOS_REPEAT_CYC (`AOS_REPEAT_MS * (`AOS_CLK_HZ / 1000))
// Default character format
`define AOS_BAUD_BPS 1200
`define AOS_BIT_CYC (`AOS_CLK_HZ / `AOS_BAUD_BPS)
`define AOS_DATA_BITS 8
`define AOS_FRAME_BITS 10
`define AOS_MSG_LEN 17
`define AOS_ALT_W 11
`define AOS_IDLE_CODE 11'h000
`endif

// ==== rtl/aos_pkg.sv ====
package aos_pkg;
  typedef enum logic [1:0] {
    AOS_ST_TEST = 2'b00,
    AOS_ST_RUN = 2'b01
  } aos_state_t;
  // Serial line group, two serial lines and a differential pair with diffNeg inverted
  typedef struct packed {
    logic primary;
    logic secondary;
    logic diffPos;
    logic diffNeg;
  } aos_serial_t;
endpackage

// ==== rtl/aos_uart_tx.sv ====
`timescale 1ns/10ps
`include "aos_params.svh"
// Start/stop serial character sender, 8N1, bit period set by parameter
module aos_uart_tx #(
  parameter int unsigned BIT_CYC = `AOS_BIT_CYC // Bit period in clocks
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic start, // Load one character
  input wire logic [7:0] data, // Character to send
  output logic busy, // Character in flight
  output logic line // Serial line, idle high
);
  logic [31:0] bitCnt;
  logic [3:0] bitIdx;
  logic [9:0] shifter;

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  // Frame is start bit, data LSB first, stop bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      line <= 1'b1;
      bitCnt <= 32'h0000_0000;
      bitIdx <= 4'h0;
      shifter <= 10'h3ff;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        shifter <= {1'b1, data, 1'b0};
        line <= 1'b0;
        bitCnt <= 32'h0000_0000;
        bitIdx <= 4'h0;
      end
    end else if (bitCnt == 32'(BIT_CYC - 1)) begin
      bitCnt <= 32'h0000_0000;
      if (bitIdx == 4'(`AOS_FRAME_BITS - 1)) begin
        busy <= 1'b0;
        line <= 1'b1;
      end else begin
        bitIdx <= bitIdx + 4'h1;
        line <= shifter[bitIdx + 4'h1];
      end
    end else begin
      bitCnt <= bitCnt + 32'h0000_0001;
    end
  end
endmodule // aos_uart_tx

// ==== rtl/aos_output_sequencer.sv ====
`timescale 1ns/10ps
`include "aos_params.svh"
module aos_output_sequencer
  import aos_pkg::*;
#(
  parameter int unsigned SELFTEST_CYC = `AOS_SELFTEST_CYC, // Self-test length
  parameter int unsigned REPEAT_CYC = `AOS_REPEAT_CYC, // Message group period
  parameter int unsigned BIT_CYC = `AOS_BIT_CYC // Serial bit period in clocks
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic [10:0] altCode, // Gray code for present pressure
  input wire logic outEnable, // Transponder enable, high enables
  input wire logic enableTiedLow, // Enable strapped to ground
  input wire logic calMode, // Calibration mode active
  input wire logic oneFootSel, // One-foot message selected
  input wire logic serialIn, // Serial receive line
  input wire logic [7:0] msgChar, // Normal message character at msgIdx
  input wire logic [7:0] fineChar, // One-foot message character at msgIdx
  output logic [4:0] msgIdx, // Character index being fetched
  output logic [10:0] altOut, // Parallel altitude outputs
  output logic altOutEn_n, // Parallel output enable, low drives
  output aos_pkg::aos_serial_t serialOut, // Serial transmit pins
  output logic calRxData, // Receive line passed on in calibration
  output logic selfTestDone // Self-test complete
);
  import aos_pkg::*;

  aos_state_t state;
  logic [31:0] testCnt;
  logic [31:0] repCnt;
  logic groupStart;
  logic sending;
  logic charStart;
  logic txBusyA;
  logic txBusyB;
  logic lineA;
  logic lineB;
  logic startPending;

  // ----------------------------------------
  // Self-test sequencing
  // ----------------------------------------
  // count from reset release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= AOS_ST_TEST;
      testCnt <= 32'h0000_0000;
    end else begin
      case (state)
        AOS_ST_TEST: begin
          if (testCnt == SELFTEST_CYC - 1) begin
            state <= AOS_ST_RUN;
          end else begin
            testCnt <= testCnt + 32'h0000_0001;
          end
        end
        AOS_ST_RUN: state <= AOS_ST_RUN;
        default: state <= AOS_ST_TEST;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selfTestDone <= 1'b0;
    end else begin
      selfTestDone <= (state == AOS_ST_RUN);
    end
  end

  // ----------------------------------------
  // Parallel outputs
  // ----------------------------------------
  // low during test; follow code afterwards
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      altOut <= `AOS_IDLE_CODE;
    end else if (state != AOS_ST_RUN) begin
      altOut <= `AOS_IDLE_CODE;
    end else begin
      altOut <= altCode;
    end
  end

  // gate by transponder enable; tie-off forces on
  // Self-test keeps outputs driven so the low level is visible
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      altOutEn_n <= 1'b0;
    end else begin
      altOutEn_n <= !(enableTiedLow || outEnable || state != AOS_ST_RUN);
    end
  end

  // ----------------------------------------
  // Message group timing
  // ----------------------------------------
  // one group every half second; enable not used here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      repCnt <= 32'h0000_0000;
      groupStart <= 1'b0;
    end else if (state != AOS_ST_RUN) begin
      repCnt <= 32'h0000_0000;
      groupStart <= 1'b0;
    end else begin
      // first group fires right after self-test
      groupStart <= (repCnt == 32'h0000_0000);
      if (repCnt == REPEAT_CYC - 1) begin
        repCnt <= 32'h0000_0000;
      end else begin
        repCnt <= repCnt + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // Character walk
  // ----------------------------------------
  // One character index serves both senders; they run in lock step
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sending <= 1'b0;
      msgIdx <= 5'h00;
      charStart <= 1'b0;
      startPending <= 1'b0;
    end else begin
      charStart <= 1'b0;
      if (!sending) begin
        if (groupStart) begin
          sending <= 1'b1;
          msgIdx <= 5'h00;
          startPending <= 1'b1;
        end
      end else if (startPending) begin
        charStart <= 1'b1;
        startPending <= 1'b0;
      end else if (!charStart && !txBusyA && !txBusyB) begin
        if (msgIdx == 5'(`AOS_MSG_LEN - 1)) begin
          sending <= 1'b0;
        end else begin
          msgIdx <= msgIdx + 5'h01;
          startPending <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Senders
  // ----------------------------------------
  // default 8N1 at 1200 bit/s
  aos_uart_tx #(.BIT_CYC(BIT_CYC)) txPrimary (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(charStart),
    .data(msgChar),
    .busy(txBusyA),
    .line(lineA)
  );

  // one-foot message only on the secondary line
  aos_uart_tx #(.BIT_CYC(BIT_CYC)) txSecondary (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(charStart),
    .data(oneFootSel ? fineChar : msgChar),
    .busy(txBusyB),
    .line(lineB)
  );

  // differential copy of the primary stream
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      serialOut <= '{primary: 1'b1, secondary: 1'b1, diffPos: 1'b1, diffNeg: 1'b0};
    end else begin
      serialOut <= '{primary: lineA, secondary: lineB, diffPos: lineA, diffNeg: !lineA};
    end
  end

  // receive line passed on only in calibration
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      calRxData <= 1'b1;
    end else begin
      calRxData <= calMode ? serialIn : 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_test_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    state == AOS_ST_TEST |=> altOut == `AOS_IDLE_CODE)
    else $error("parallel outputs not low in self-test");
  chk_code_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    state == AOS_ST_RUN |=> altOut == $past(altCode))
    else $error("parallel outputs not following code");
  chk_enable_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state == AOS_ST_RUN && !outEnable && !enableTiedLow) |=> altOutEn_n)
    else $error("outputs driven without enable");
  chk_tied_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    enableTiedLow |=> !altOutEn_n)
    else $error("tied enable did not keep outputs on");
  chk_no_early_tx: assert property (@(posedge clk_sys) disable iff (!resetn)
    state == AOS_ST_TEST |-> !sending && !charStart)
    else $error("serial sent before self-test end");
  chk_rx_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
    !calMode |=> calRxData)
    else $error("receive line used outside calibration");
  chk_diff_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
    serialOut.diffPos != serialOut.diffNeg && serialOut.diffPos == serialOut.primary)
    else $error("differential pair not complementary");
  chk_group_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(state == AOS_ST_RUN) |-> ##2 sending)
    else $error("group did not start after self-test");
endmodule // aos_output_sequencer

// ==== tb/aos_far_side.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Navigation receiver seen from the serial pins
// ----------------------------------------
module aos_far_side
  import aos_pkg::*;
#(
  parameter int unsigned BIT_CYC = 8 // Bit period in clocks
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [4:0] msgIdx, // Character index asked for
  input wire aos_pkg::aos_serial_t serialOut, // Serial pins watched
  output logic [7:0] msgChar, // Normal message character
  output logic [7:0] fineChar, // One-foot message character
  output logic [7:0] frameCount // Start bits seen on primary
);
  import aos_pkg::*;
  logic lastLine;
  logic [15:0] holdCnt;
  // Character source answers at once, as a table lookup would
  assign msgChar = 8'h41 + {3'h0, msgIdx};
  assign fineChar = 8'h61 + {3'h0, msgIdx};
  // Count frames on primary: a start edge opens a frame, data falls inside it are ignored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lastLine <= 1'b1;
      holdCnt <= 16'h0000;
      frameCount <= 8'h00;
    end else begin
      lastLine <= serialOut.primary;
      if (holdCnt != 16'h0000) begin
        holdCnt <= holdCnt - 16'h0001;
        if (holdCnt == 16'h0001) frameCount <= frameCount + 8'h01;
      end else if (lastLine && !serialOut.primary) begin
        // Hold until the middle of the stop bit
        holdCnt <= 16'(BIT_CYC * 19 / 2);
      end
    end
  end
endmodule // aos_far_side

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  import aos_pkg::*;
  localparam int unsigned ST = 100;
  localparam int unsigned BC = 8;
  localparam int unsigned RP = 2000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [10:0] altCode = 11'h5a3;
  logic outEnable = 1'b0;
  logic enableTiedLow = 1'b0;
  logic calMode = 1'b0;
  logic oneFootSel = 1'b1;
  logic serialIn = 1'b0;
  logic [7:0] msgChar, fineChar, frameCount;
  logic [4:0] msgIdx;
  logic [10:0] altOut;
  logic altOutEn_n, calRxData, selfTestDone;
  aos_serial_t serialOut;
  int err_count = 0;
  int check_count = 0;
  int cycNow = 0;
  // ----------------------------------------
  // Clock, partner and block
  // ----------------------------------------
  always #4 clk_sys = ~clk_sys;
  // Edge counter, read at falling edges to time the serial groups
  always @(posedge clk_sys) cycNow <= cycNow + 1;
  aos_far_side #(.BIT_CYC(BC)) far (.clk_sys(clk_sys), .resetn(resetn), .msgIdx(msgIdx),
    .serialOut(serialOut), .msgChar(msgChar), .fineChar(fineChar), .frameCount(frameCount));
  // Short bit period and group period so whole groups fit in the run
  aos_output_sequencer #(.SELFTEST_CYC(ST), .REPEAT_CYC(RP), .BIT_CYC(BC)) dut (
    .clk_sys(clk_sys),
    .resetn(resetn), .altCode(altCode), .outEnable(outEnable), .enableTiedLow(enableTiedLow),
    .calMode(calMode), .oneFootSel(oneFootSel), .serialIn(serialIn), .msgChar(msgChar),
    .fineChar(fineChar), .msgIdx(msgIdx), .altOut(altOut), .altOutEn_n(altOutEn_n),
    .serialOut(serialOut), .calRxData(calRxData), .selfTestDone(selfTestDone));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Inputs move on the falling edge, registered outputs are settled there too
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Called on the falling edge at which resetn is released
  task automatic t_selftest;
    for (int i = 0; i < ST; i++) begin
      altCode <= altCode ^ 11'h7ff;
      outEnable <= i[0];
      cyc(1);
      chk("altOut", altOut, 11'h000);
      chk("altOutEn_n", 11'(altOutEn_n), 11'h000);
      chk("serialOut", 11'(serialOut), 11'h00e);
      chk("selfTestDone", 11'(selfTestDone), 11'h000);
    end
    cyc(1);
    chk("selfTestDone", 11'(selfTestDone), 11'h001);
    chk("altOutRun", altOut, altCode);
    $display("test selftest done");
  endtask
  // Decode one character on both serial lines at mid-bit while strobing the enable
  task automatic rx_char(input logic [7:0] expA, input logic [7:0] expB);
    logic [9:0] frmA;
    logic [9:0] frmB;
    logic bitA;
    frmA = {1'b1, expA, 1'b0};
    frmB = {1'b1, expB, 1'b0};
    for (int i = 0; i < 10 * BC; i++) begin
      outEnable <= ~outEnable;
      enableTiedLow <= i[4];
      cyc(1);
      if (i % BC == BC / 2) begin
        bitA = frmA[i / BC];
        // enable strobing leaves the line alone
        chk("primary", 11'(serialOut.primary), 11'(bitA));
        chk("secondary", 11'(serialOut.secondary), 11'(frmB[i / BC]));
        chk("diffPair", 11'({serialOut.diffPos, serialOut.diffNeg}), 11'({bitA, !bitA}));
      end
    end
  endtask
  task automatic t_serial;
    int n;
    int t0;
    for (n = 0; n < 10 && serialOut.primary !== 1'b0; n++) cyc(1);
    // first start bit follows self-test end with no request
    chk("startDelay", 11'(n), 11'h004);
    // start bit on every serial pin, pair inverted
    chk("startBit", 11'(serialOut), 11'h001);
    chk("msgIdx", 11'(msgIdx), 11'h000);
    t0 = cycNow;
    rx_char(8'h41, 8'h61);
    for (n = 0; n < RP && frameCount != 8'h11; n++) cyc(1);
    chk("frames", 11'(frameCount), 11'h011);
    chk("lastIdx", 11'(msgIdx), 11'h010);
    oneFootSel <= 1'b0;
    for (n = 0; n < RP && serialOut.primary !== 1'b0; n++) cyc(1);
    // next group one repetition period after the first
    chk("period", 11'(cycNow - t0), 11'(RP));
    chk("framesHeld", 11'(frameCount), 11'h011);
    rx_char(8'h41, 8'h41);
    $display("test serial done");
  endtask
  task automatic t_parallel;
    for (int i = 0; i < 8; i++) begin
      altCode <= 11'h0f0 + 11'(i);
      outEnable <= i[0];
      enableTiedLow <= i[1] & i[2];
      cyc(2);
      chk("altOut", altOut, 11'h0f0 + 11'(i));
      chk("altOutEn_n", 11'(altOutEn_n), 11'(!(i[0] | (i[1] & i[2]))));
    end
    $display("test parallel done");
  endtask
  task automatic t_cal;
    for (int i = 0; i < 8; i++) begin
      calMode <= i[2];
      serialIn <= i[0];
      cyc(2);
      chk("calRxData", 11'(calRxData), 11'(i[2] ? i[0] : 1'b1));
    end
    $display("test cal done");
  endtask
  // Mid-run reset: outputs return to reset values and the self-test runs again
  task automatic t_reset;
    resetn <= 1'b0;
    cyc(2);
    chk("rstAltOut", altOut, 11'h000);
    chk("rstSerial", 11'(serialOut), 11'h00e);
    chk("rstMsgIdx", 11'(msgIdx), 11'h000);
    chk("rstDone", 11'(selfTestDone), 11'h000);
    chk("rstCalRx", 11'(calRxData), 11'h001);
    resetn <= 1'b1;
    t_selftest();
    $display("test reset done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(20);
    resetn <= 1'b1;
    t_selftest();
    t_serial();
    t_parallel();
    t_cal();
    t_reset();
    end_of_test();
  end
  // Whole run is a few thousand cycles; this leaves wide margin
  initial begin
    #(8 * 20000);
    err_count++;
    end_of_test();
  end
endmodule // tb
